// [hdl/smc_regs.sv]
// Function
// - Identity byte fixed, read only, writes ignored
// - Storage byte read back unchanged, no effect
// - Active power level field in bits 2:0
// - Idle watch power level in bits 6:4
// - Fast serial enable bit always reads zero
// - X bits 2/3 push positive/negative
// - Y bits 2/3 push positive/negative
// - Y reads 0x80 awake, 0x00 asleep
// - Z bits 2/3 push, host zeroes others
// - Any reset restores four-wire serial wiring
// - Bit 6 runs full restart, self clears
// - Bit 7 copies store, busy shown meanwhile
module smc_regs #(
    parameter logic [7:0] IDENTITY_CODE = 8'h5A // Arbitrary value
) (
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_rstn,
    input  wire logic                       i_wr_en,
    input  wire logic                       i_rd_en,
    input  wire logic [7:0]                 i_addr,
    input  wire logic [7:0]                 i_wdata,
    input  wire logic [2:0]                 i_op_state,
    input  wire logic                       i_three_wire_req,
    output logic      [7:0]                 o_rdata,
    output logic                            o_rd_valid,
    output logic      [smc_pkg::PWR_W-1:0]  o_active_power_level,
    output logic      [smc_pkg::PWR_W-1:0]  o_idle_watch_power_level,
    output logic                            o_fast_serial_enable,
    output logic                            o_x_push_positive,
    output logic                            o_x_push_negative,
    output logic                            o_y_push_positive,
    output logic                            o_y_push_negative,
    output logic                            o_z_push_positive,
    output logic                            o_z_push_negative,
    output logic                            o_three_wire,
    output logic                            o_soft_reset,
    output logic                            o_otp_busy,
    output logic                            o_otp_wr_valid,
    output logic      [smc_pkg::OTP_AW-1:0] o_otp_wr_addr,
    output logic      [smc_pkg::OTP_DW-1:0] o_otp_wr_data,
    output logic                            o_offset_expand
);
    import smc_pkg::*;

    smc_otp_if otp_bus ();

    // Register state
    logic [7:0]       init_reg,      init_next;
    logic [7:0]       general_storage_byte_reg,   general_storage_byte_next;
    logic [PWR_W-1:0] active_reg,    active_next;
    logic [PWR_W-1:0] idle_reg,      idle_next;
    logic             fast_reg,      fast_next;
    logic [2:0]       pos_reg,       pos_next;
    logic [2:0]       neg_reg,       neg_next;
    logic             soft_reg,      soft_next;
    logic             reload_reg,    reload_next;
    logic             three_reg,     three_next;
    logic [7:0]       rdata_reg,     rdata_next;
    logic             rd_valid_reg,  rd_valid_next;
    logic             softrst_reg,   softrst_next;

    // Sequencer state
    smc_seq_t         seq_reg,       seq_next;
    logic [OTP_AW-1:0] cnt_reg,      cnt_next;
    logic             wr_valid_reg,  wr_valid_next;
    logic [OTP_AW-1:0] wr_addr_reg,  wr_addr_next;
    logic             expand_reg,    expand_next;

    logic             idle;
    logic             wr_hit;
    logic             soft_go;
    logic             reload_go;
    logic [2:0]       push_pos;
    logic [2:0]       push_neg;
    logic [7:0]       rd_mux;

    assign idle      = (seq_reg == SEQ_IDLE);
    assign wr_hit    = i_wr_en && idle;
    assign soft_go   = wr_hit && (i_addr == ADDR_RESTART) && i_wdata[BIT_SOFT_RESET];
    assign reload_go = wr_hit && (i_addr == ADDR_RESTART) && !i_wdata[BIT_SOFT_RESET] &&
                       i_wdata[BIT_RELOAD] && !reload_reg;

    // Register writes; a restart puts every field back to its default except the restart bit, which it sets
    always_comb begin
        init_next    = init_reg;
        general_storage_byte_next = general_storage_byte_reg;
        active_next  = active_reg;
        idle_next    = idle_reg;
        fast_next    = fast_reg;
        pos_next     = pos_reg;
        neg_next     = neg_reg;
        soft_next    = soft_reg;
        reload_next  = reload_reg;
        three_next   = three_reg;
        softrst_next = 1'b0;
        if (i_three_wire_req) begin
            three_next = 1'b1;
        end
        if (soft_go) begin
            init_next    = RST_BYTE;
            general_storage_byte_next = RST_BYTE;
            active_next  = PWR_LOW;
            idle_next    = PWR_LOW;
            fast_next    = 1'b0;
            pos_next     = '0;
            neg_next     = '0;
            reload_next  = 1'b0;
            soft_next    = 1'b1;
            softrst_next = 1'b1;
            three_next   = 1'b0;
        end else if (wr_hit) begin
            if (i_addr == ADDR_INIT) begin
                init_next = i_wdata;
            end else if (i_addr == ADDR_GENERAL_STORAGE_BYTE) begin
                general_storage_byte_next = i_wdata;
            end else if (i_addr == ADDR_POWER) begin
                active_next = i_wdata[ACTIVE_LSB +: PWR_W];
                idle_next   = i_wdata[IDLE_LSB +: PWR_W];
                fast_next   = i_wdata[BIT_FAST_SERIAL];
            end else if (i_addr == ADDR_XACT) begin
                pos_next[0] = i_wdata[BIT_PUSH_POS];
                neg_next[0] = i_wdata[BIT_PUSH_NEG];
            end else if (i_addr == ADDR_YACT) begin
                pos_next[1] = i_wdata[BIT_PUSH_POS];
                neg_next[1] = i_wdata[BIT_PUSH_NEG];
            end else if (i_addr == ADDR_ZACT) begin
                pos_next[2] = i_wdata[BIT_PUSH_POS];
                neg_next[2] = i_wdata[BIT_PUSH_NEG];
            end else if (i_addr == ADDR_RESTART) begin
                reload_next = i_wdata[BIT_RELOAD];
            end
        end
        if (seq_reg == SEQ_EXPAND) begin
            soft_next = 1'b0;
        end
    end

    // Read side; registered answer one cycle after the strobe
    always_comb begin
        if (i_addr == ADDR_ID) begin
            rd_mux = IDENTITY_CODE;
        end else if (i_addr == ADDR_INIT) begin
            rd_mux = init_reg;
        end else if (i_addr == ADDR_GENERAL_STORAGE_BYTE) begin
            rd_mux = general_storage_byte_reg;
        end else if (i_addr == ADDR_POWER) begin
            rd_mux = {1'b0, idle_reg, 1'b0, active_reg};
        end else if (i_addr == ADDR_YACT) begin
            rd_mux = smc_is_awake(i_op_state) ? Y_AWAKE_READ : Y_ASLEEP_READ;
        end else if (i_addr == ADDR_ZACT) begin
            rd_mux = {4'h0, neg_reg[2], pos_reg[2], 2'h0};
        end else if (i_addr == ADDR_RESTART) begin
            rd_mux = {reload_reg, soft_reg, 6'h00};
        end else begin
            rd_mux = UNMAPPED_READ;
        end
        rd_valid_next = i_rd_en;
        rdata_next    = i_rd_en ? rd_mux : rdata_reg;
    end

    // Store copy: issue address, data returns a cycle later
    always_comb begin
        seq_next      = seq_reg;
        cnt_next      = cnt_reg;
        wr_valid_next = 1'b0;
        wr_addr_next  = wr_addr_reg;
        expand_next   = 1'b0;
        otp_bus.en    = 1'b0;
        otp_bus.addr  = cnt_reg;
        case (seq_reg)
            SEQ_IDLE: begin
                cnt_next = OTP_FIRST;
                if (soft_go || reload_go) begin
                    seq_next = SEQ_LOAD;
                end
            end
            SEQ_LOAD: begin
                otp_bus.en    = 1'b1;
                wr_valid_next = 1'b1;
                wr_addr_next  = cnt_reg;
                cnt_next      = cnt_reg + 1'b1;
                if (cnt_reg == OTP_LAST) begin
                    seq_next = SEQ_DRAIN;
                end
            end
            SEQ_DRAIN: begin
                seq_next = soft_reg ? SEQ_EXPAND : SEQ_IDLE;
                if (soft_reg) begin
                    expand_next = 1'b1;
                end
            end
            SEQ_EXPAND: begin
                seq_next = SEQ_IDLE;
            end
            default: begin
                seq_next = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            init_reg     <= RST_BYTE;
            general_storage_byte_reg  <= RST_BYTE;
            active_reg   <= PWR_LOW;
            idle_reg     <= PWR_LOW;
            fast_reg     <= 1'b0;
            pos_reg      <= '0;
            neg_reg      <= '0;
            soft_reg     <= 1'b0;
            reload_reg   <= 1'b0;
            three_reg    <= 1'b0;
            rdata_reg    <= RST_BYTE;
            rd_valid_reg <= 1'b0;
            softrst_reg  <= 1'b0;
            seq_reg      <= SEQ_IDLE;
            cnt_reg      <= OTP_FIRST;
            wr_valid_reg <= 1'b0;
            wr_addr_reg  <= OTP_FIRST;
            expand_reg   <= 1'b0;
        end else begin
            init_reg     <= init_next;
            general_storage_byte_reg  <= general_storage_byte_next;
            active_reg   <= active_next;
            idle_reg     <= idle_next;
            fast_reg     <= fast_next;
            pos_reg      <= pos_next;
            neg_reg      <= neg_next;
            soft_reg     <= soft_next;
            reload_reg   <= reload_next;
            three_reg    <= three_next;
            rdata_reg    <= rdata_next;
            rd_valid_reg <= rd_valid_next;
            softrst_reg  <= softrst_next;
            seq_reg      <= seq_next;
            cnt_reg      <= cnt_next;
            wr_valid_reg <= wr_valid_next;
            wr_addr_reg  <= wr_addr_next;
            expand_reg   <= expand_next;
        end
    end

    // Opposing push bits cancel on each axis
    for (genvar ax = 0; ax < 3; ax++) begin : g_axis
        assign push_pos[ax] = pos_reg[ax] && !neg_reg[ax];
        assign push_neg[ax] = neg_reg[ax] && !pos_reg[ax];
    end

    smc_otp_mem u_otp (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .otp       (otp_bus.mem)
    );

    assign o_rdata                  = rdata_reg;
    assign o_rd_valid               = rd_valid_reg;
    assign o_active_power_level     = active_reg;
    assign o_idle_watch_power_level = idle_reg;
    assign o_fast_serial_enable     = fast_reg;
    assign o_x_push_positive        = push_pos[0];
    assign o_x_push_negative        = push_neg[0];
    assign o_y_push_positive        = push_pos[1];
    assign o_y_push_negative        = push_neg[1];
    assign o_z_push_positive        = push_pos[2];
    assign o_z_push_negative        = push_neg[2];
    assign o_three_wire             = three_reg;
    assign o_soft_reset             = softrst_reg;
    assign o_otp_busy               = !idle;
    assign o_otp_wr_valid           = wr_valid_reg;
    assign o_otp_wr_addr            = wr_addr_reg;
    assign o_otp_wr_data            = otp_bus.rd_data;
    assign o_offset_expand          = expand_reg;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    a_id_fixed: assert property (
        i_rd_en && i_addr == ADDR_ID |=> o_rd_valid && o_rdata == IDENTITY_CODE)
        else $error("identity byte wrong");
    a_general_storage_byte_back: assert property (
        (wr_hit && i_addr == ADDR_GENERAL_STORAGE_BYTE && !soft_go) ##1 !i_wr_en ##1
        (i_rd_en && i_addr == ADDR_GENERAL_STORAGE_BYTE && !i_wr_en)
        |=> o_rdata == $past(i_wdata, 3))
        else $error("storage byte not returned");
    a_active_level: assert property (
        wr_hit && i_addr == ADDR_POWER |=> o_active_power_level == $past(i_wdata[2:0]))
        else $error("active level not taken");
    a_idle_level: assert property (
        wr_hit && i_addr == ADDR_POWER |=> o_idle_watch_power_level == $past(i_wdata[6:4]))
        else $error("idle level not taken");
    a_fast_zero: assert property (
        i_rd_en && i_addr == ADDR_POWER |=> !o_rdata[7] && !o_rdata[3])
        else $error("fast serial bit read nonzero");
    a_x_push: assert property (
        wr_hit && i_addr == ADDR_XACT && i_wdata == 8'h05
        |=> o_x_push_positive && !o_x_push_negative)
        else $error("x push not applied");
    a_y_readback: assert property (
        i_rd_en && i_addr == ADDR_YACT
        |=> o_rdata == (smc_is_awake($past(i_op_state)) ? 8'h80 : 8'h00))
        else $error("y readback wrong");
    a_push_cancel: assert property (
        wr_hit && i_addr == ADDR_ZACT && i_wdata == 8'h0C
        |=> !o_z_push_positive && !o_z_push_negative)
        else $error("opposing push not cancelled");
    a_wire_default: assert property (
        soft_go |=> !o_three_wire && o_soft_reset)
        else $error("wiring not restored");
    a_restart_seq: assert property (
        soft_go |-> ##18 o_offset_expand ##1 (!o_otp_busy && !soft_reg))
        else $error("restart sequence timing wrong");
    a_reload_busy: assert property (
        reload_go |=> o_otp_busy [*8] ##10 !o_otp_busy)
        else $error("reload busy wrong");
    a_reload_kept: assert property (
        reload_go |-> ##19 reload_reg)
        else $error("reload bit cleared by hardware");

    c_soft: cover property (soft_go ##19 idle);
    c_reload: cover property (reload_go ##18 idle);
    c_y_awake: cover property (i_rd_en && i_addr == ADDR_YACT && smc_is_awake(i_op_state));
    c_general_storage_byte: cover property (wr_hit && i_addr == ADDR_GENERAL_STORAGE_BYTE);

endmodule // smc_regs

// [inc/smc_pkg.sv]
package smc_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_ID      = 8'h18;
    localparam logic [7:0] ADDR_INIT    = 8'h1A;
    localparam logic [7:0] ADDR_GENERAL_STORAGE_BYTE = 8'h1B;
    localparam logic [7:0] ADDR_POWER   = 8'h1C;
    localparam logic [7:0] ADDR_XACT    = 8'h20;
    localparam logic [7:0] ADDR_YACT    = 8'h21;
    localparam logic [7:0] ADDR_ZACT    = 8'h22;
    localparam logic [7:0] ADDR_RESTART = 8'h24;

    // Field positions
    localparam int PWR_W           = 3;
    localparam int ACTIVE_LSB      = 0;
    localparam int IDLE_LSB        = 4;
    localparam int BIT_FAST_SERIAL = 7;
    localparam int BIT_PUSH_POS    = 2;
    localparam int BIT_PUSH_NEG    = 3;
    localparam int BIT_SOFT_RESET  = 6;
    localparam int BIT_RELOAD      = 7;

    // Power level codes, others reserved
    localparam logic [2:0] PWR_LOW       = 3'h0;
    localparam logic [2:0] PWR_ULTRA_LOW = 3'h3;
    localparam logic [2:0] PWR_PRECISION = 3'h4;

    // Reset and readback values
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [7:0] Y_AWAKE_READ  = 8'h80;
    localparam logic [7:0] Y_ASLEEP_READ = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Operating state codes seen on i_op_state
    localparam logic [2:0] ST_SLEEP   = 3'h0;
    localparam logic [2:0] ST_STANDBY = 3'h1;
    localparam logic [2:0] ST_WATCH   = 3'h2;
    localparam logic [2:0] ST_CONTINUOUS_WAKE_STATE   = 3'h5;
    localparam logic [2:0] ST_SNIFF_WAKE_STATE   = 3'h6;
    localparam logic [2:0] ST_BURST   = 3'h7;

    // Non-volatile store geometry
    localparam int             OTP_AW    = 4;
    localparam int             OTP_DW    = 8;
    localparam int             OTP_DEPTH = 16;
    localparam logic [OTP_AW-1:0] OTP_LAST = 4'hF;
    localparam logic [OTP_AW-1:0] OTP_FIRST = 4'h0;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_LOAD,
        SEQ_DRAIN,
        SEQ_EXPAND
    } smc_seq_t;

    function automatic logic smc_is_awake(input logic [2:0] st);
        smc_is_awake = (st == ST_WATCH) || (st == ST_CONTINUOUS_WAKE_STATE) ||
                       (st == ST_SNIFF_WAKE_STATE) || (st == ST_BURST);
    endfunction

endpackage

// [inc/smc_otp_if.sv]
interface smc_otp_if;
    import smc_pkg::*;
    logic              en;
    logic [OTP_AW-1:0] addr;
    logic [OTP_DW-1:0] rd_data;
    modport ctrl (output en, output addr, input rd_data);
    modport mem  (input en, input addr, output rd_data);
endinterface

// [hdl/smc_otp_mem.sv]
module smc_otp_mem #(
    parameter logic [smc_pkg::OTP_DEPTH*smc_pkg::OTP_DW-1:0] CONTENT = '0
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    smc_otp_if.mem    otp
);
    import smc_pkg::*;

    logic [OTP_DW-1:0] rd_data_reg;
    logic [OTP_DW-1:0] rd_data_next;

    // Core only delivers data while enabled
    always_comb begin
        rd_data_next = rd_data_reg;
        if (otp.en) begin
            rd_data_next = CONTENT[otp.addr*OTP_DW +: OTP_DW];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign otp.rd_data = rd_data_reg;

endmodule // smc_otp_mem

// [tb/smc_host_model.sv]
module smc_host_model (
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rd_valid,
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    import smc_pkg::*;

    logic fast_serial_shadow;

    initial begin
        o_wr_en            = 1'b0;
        o_rd_en            = 1'b0;
        o_addr             = 8'h00;
        o_wdata            = 8'h00;
        fast_serial_shadow = 1'b0;
    end

    // Released address and data show the inverse of the last value
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clk_sys);
        #1;
        o_addr  = addr;
        o_wdata = data;
        o_wr_en = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_wr_en = 1'b0;
        o_addr  = ~addr;
        o_wdata = ~data;
        if (addr == ADDR_POWER) begin
            fast_serial_shadow = data[BIT_FAST_SERIAL];
        end
    endtask

    // Answer sampled in the cycle after the strobe
    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic vld);
        @(posedge i_clk_sys);
        #1;
        o_addr  = addr;
        o_rd_en = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_rd_en = 1'b0;
        o_addr  = ~addr;
        data    = i_rdata;
        vld     = i_rd_valid;
    endtask

    // Startup writes after every reset
    task automatic init();
        wr(ADDR_INIT, 8'h00);
        wr(ADDR_XACT, 8'h01);
        wr(ADDR_YACT, 8'h80);
    endtask
endmodule // smc_host_model

// [tb/test_sensor_misc_control_regs.sv]
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module test_sensor_misc_control_regs;
    timeunit 1ns;
    timeprecision 100ps;
    import smc_pkg::*;

    localparam logic [7:0] ID_CODE = 8'hA6; // Arbitrary value

    logic       i_clk_sys, i_rstn, i_wr_en, i_rd_en, i_three_wire_req;
    logic [7:0] i_addr, i_wdata, o_rdata, o_otp_wr_data;
    logic [2:0] i_op_state, o_active_power_level, o_idle_watch_power_level;
    logic       o_rd_valid, o_fast_serial_enable, o_three_wire, o_soft_reset;
    logic       o_otp_busy, o_otp_wr_valid, o_offset_expand;
    logic [5:0] pushv;
    logic [3:0] o_otp_wr_addr;
    int         n_mismatch, tests_run, n_words, n_expand;
    logic [31:0] lfsr = 32'h0E3B;

    smc_regs #(.IDENTITY_CODE(ID_CODE)) dut (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_op_state(i_op_state),
        .i_three_wire_req(i_three_wire_req), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
        .o_active_power_level(o_active_power_level),
        .o_idle_watch_power_level(o_idle_watch_power_level),
        .o_fast_serial_enable(o_fast_serial_enable),
        .o_x_push_positive(pushv[0]), .o_x_push_negative(pushv[1]),
        .o_y_push_positive(pushv[2]), .o_y_push_negative(pushv[3]),
        .o_z_push_positive(pushv[4]), .o_z_push_negative(pushv[5]),
        .o_three_wire(o_three_wire), .o_soft_reset(o_soft_reset), .o_otp_busy(o_otp_busy),
        .o_otp_wr_valid(o_otp_wr_valid), .o_otp_wr_addr(o_otp_wr_addr),
        .o_otp_wr_data(o_otp_wr_data), .o_offset_expand(o_offset_expand));

    smc_host_model host (
        .i_clk_sys(i_clk_sys), .i_rdata(o_rdata), .i_rd_valid(o_rd_valid),
        .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wdata(i_wdata));

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    function automatic logic [7:0] exp_y(input logic [2:0] st);
        return (st inside {ST_WATCH, ST_CONTINUOUS_WAKE_STATE, ST_SNIFF_WAKE_STATE, ST_BURST}) ? 8'h80 : 8'h00;
    endfunction

    task automatic complete_run();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        host.rd(addr, d, v);
        `CHK(v, 1'b1)
        `CHK(d, exp)
    endtask

    task automatic chk_defaults();
        logic [7:0] ad [8] = '{ADDR_ID, ADDR_INIT, ADDR_GENERAL_STORAGE_BYTE, ADDR_POWER, ADDR_XACT,
                               ADDR_ZACT, ADDR_RESTART, 8'h30};
        for (int i = 0; i < 8; i++) begin
            chk_rd(ad[i], (i == 0) ? ID_CODE : RST_BYTE);
        end
        `CHK({o_active_power_level, o_idle_watch_power_level, o_fast_serial_enable}, 7'h00)
        `CHK(pushv, 6'h00)
    endtask

    task automatic restart(input logic [7:0] data, input int exp_expand);
        int k;
        n_words  = 0;
        n_expand = 0;
        host.wr(ADDR_RESTART, data);
        `CHK(o_otp_busy, 1'b1)
        `CHK(o_soft_reset, data[BIT_SOFT_RESET])
        if (data[BIT_SOFT_RESET]) begin
            `CHK(o_three_wire, 1'b0)
        end
        host.wr(ADDR_GENERAL_STORAGE_BYTE, 8'hC3);
        k = 0;
        while (o_otp_busy === 1'b1 && k < 40) begin
            @(posedge i_clk_sys);
            #1;
            k++;
        end
        `CHK(k < 40, 1'b1)
        `CHK(n_words, OTP_DEPTH)
        `CHK(n_expand, exp_expand)
    endtask

    task automatic pulse_three_wire();
        @(posedge i_clk_sys);
        #1;
        i_three_wire_req = 1'b1;
        @(posedge i_clk_sys);
        #1;
        i_three_wire_req = 1'b0;
        `CHK(o_three_wire, 1'b1)
    endtask

    // Store copy monitor
    always @(posedge i_clk_sys) begin
        if (o_otp_wr_valid === 1'b1) begin
            `CHK({o_otp_wr_addr, o_otp_wr_data}, {4'(n_words), 8'h00})
            n_words++;
        end
        if (o_offset_expand === 1'b1) begin
            n_expand++;
        end
    end

    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    initial begin
        #(20 * 20000);
        n_mismatch++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        logic [2:0] codes [4];
        logic [2:0] st [6];
        logic [7:0] d, base;
        logic       fs;
        n_mismatch       = 0;
        tests_run        = 0;
        st               = '{ST_SLEEP, ST_STANDBY, ST_WATCH, ST_CONTINUOUS_WAKE_STATE, ST_SNIFF_WAKE_STATE, ST_BURST};
        i_rstn           = 1'b0;
        i_op_state       = ST_SLEEP;
        i_three_wire_req = 1'b0;
        repeat (2) @(posedge i_clk_sys);
        #1;
        i_rstn = 1'b1;
        chk_defaults();
        chk_rd(ADDR_YACT, 8'h00);
        host.init();
        chk_rd(ADDR_INIT, 8'h00);
        host.wr(ADDR_ID, 8'(rnd()));
        chk_rd(ADDR_ID, ID_CODE);
        for (int i = 0; i < 8; i++) begin
            d = 8'(rnd());
            host.wr(ADDR_GENERAL_STORAGE_BYTE, d);
            chk_rd(ADDR_GENERAL_STORAGE_BYTE, d);
            `CHK({o_active_power_level, pushv}, 9'h000)
        end
        codes = '{PWR_LOW, PWR_ULTRA_LOW, PWR_PRECISION, 3'(rnd())};
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 4; j++) begin
                fs = 1'(rnd());
                host.wr(ADDR_POWER, {fs, codes[j], 1'b1, codes[i]});
                `CHK({o_fast_serial_enable, o_idle_watch_power_level}, {fs, codes[j]})
                `CHK(o_active_power_level, codes[i])
                `CHK(o_fast_serial_enable, host.fast_serial_shadow)
                chk_rd(ADDR_POWER, {1'b0, codes[j], 1'b0, codes[i]});
            end
        end
        for (int ax = 0; ax < 3; ax++) begin
            base = (ax == 0) ? 8'h01 : ((ax == 1) ? 8'h80 : 8'h00);
            for (int v = 0; v < 4; v++) begin
                d = base | {4'h0, 2'(v), 2'b00};
                host.wr(ADDR_XACT + 8'(ax), d);
                `CHK(pushv, 6'({v[1] & ~v[0], v[0] & ~v[1]}) << (2 * ax))
                chk_rd(ADDR_XACT + 8'(ax), (ax == 2) ? d : (ax == 1 ? 8'h00 : 8'h00));
            end
        end
        for (int i = 0; i < 6; i++) begin
            i_op_state = st[i];
            chk_rd(ADDR_YACT, exp_y(st[i]));
        end
        i_op_state = ST_SLEEP;
        host.wr(ADDR_GENERAL_STORAGE_BYTE, 8'h3C);
        host.wr(ADDR_POWER, 8'h43);
        pulse_three_wire();
        restart(8'h40, 1);
        chk_defaults();
        host.init();
        host.wr(ADDR_GENERAL_STORAGE_BYTE, 8'h3C);
        restart(8'h80, 0);
        chk_rd(ADDR_GENERAL_STORAGE_BYTE, 8'h3C);
        chk_rd(ADDR_RESTART, 8'h80);
        host.wr(ADDR_RESTART, 8'h00);
        chk_rd(ADDR_RESTART, 8'h00);
        pulse_three_wire();
        @(posedge i_clk_sys);
        #1;
        i_rstn = 1'b0;
        #2;
        `CHK(o_three_wire, 1'b0)
        @(posedge i_clk_sys);
        #1;
        i_rstn = 1'b1;
        host.init();
        chk_rd(ADDR_GENERAL_STORAGE_BYTE, RST_BYTE);
        complete_run();
    end
endmodule // test_sensor_misc_control_regs
